/* File: dv/wdt_control_tb.sv */
// Self-checking bench for the watchdog control block.
// Assumes the logic/ files are compiled first; one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module wdt_control_tb;
  import wdt_pkg::*;
  logic       clk;
  logic       rst;
  logic       wr;
  logic       idone;
  logic       smon;
  logic       gie;
  logic [7:0] wdata;
  wire  [7:0] rdata;
  wire        irq;
  wire        sres;
  int         error_cnt;
  int         tests_run;
  int         hits;
  int         irqs;
  // Core cycles per 32.768 kHz tick at 50 MHz, rounded down
  localparam int TICK_CYC = 50000000 / 32768;

  wdt_control wdt_control_inst (
    .CORE_CLK          (clk),
    .RESET             (rst),
    .CTRL_WR           (wr),
    .CTRL_WDATA        (wdata),
    .INSTR_DONE        (idone),
    .CTRL_RDATA        (rdata),
    .SUPPLY_MONITOR_IRQ(smon),
    .GLOBAL_IRQ_ENABLE (gie),
    .WDT_IRQ           (irq),
    .WDT_SYS_RESET     (sres)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One write instruction; its own end-of-instruction pulse rides along
  task automatic wr1(input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    wdata <= d;
    idone <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    idone <= 1'b0;
  endtask

  // Unlock then write, then let the register settle
  task automatic lk(input logic [7:0] d);
    wr1(8'h01);
    wr1(d);
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("ctrl after reset", rdata, 8'h10);
    $display("test reset done");
  endtask

  task automatic t_lock;
    wr1(8'h72);
    @(posedge clk);
    #1;
    chk("ctrl lone write", rdata & 8'hFE, 8'h10);
    wr1(8'h01);
    @(posedge clk);
    idone <= 1'b1;
    @(posedge clk);
    idone <= 1'b0;
    wr1(8'h72);
    @(posedge clk);
    #1;
    chk("ctrl late write", rdata & 8'hFE, 8'h10);
    lk(8'h72);
    chk("ctrl unlocked", rdata, 8'h72);
    lk(8'h70);
    chk("ctrl disable", rdata, 8'h70);
    $display("test lock done");
  endtask

  // Supply monitor knocks the enable down without a write
  task automatic t_smon;
    lk(8'h72);
    chk("ctrl enabled", rdata, 8'h72);
    @(posedge clk);
    smon <= 1'b1;
    @(posedge clk);
    smon <= 1'b0;
    @(posedge clk);
    #1;
    chk("ctrl after monitor", rdata, 8'h70);
    $display("test monitor done");
  endtask

  // Counter steps once per timebase tick; a refresh zeroes it
  task automatic t_count;
    lk(8'h02);
    chk("period code 0", wdt_control_inst.limit[15:8], 8'h02);
    repeat (3 * TICK_CYC + 8) @(posedge clk);
    #1;
    chk("ticks counted", wdt_control_inst.cnt_reg[7:0], 8'h03);
    lk(8'h02);
    chk("ticks after refresh", wdt_control_inst.cnt_reg[7:0], 8'h00);
    lk(8'h30);
    chk("ctrl off", rdata, 8'h30);
    chk("period code 3", wdt_control_inst.limit[15:8], 8'h10);
    $display("test count done");
  endtask

  task automatic t_immed;
    lk(8'h82);
    hits = 0;
    irqs = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (sres === 1'b1) hits++;
      if (irq === 1'b1) irqs++;
    end
    chk("reset pulses", 8'(hits > 0), 8'h01);
    chk("irq pulses", 8'(irqs), 8'h00);
    chk("flag and enable", {6'h00, rdata[2:1]}, 8'h02);
    lk(8'h14);
    chk("ctrl flag kept", rdata, 8'h14);
    lk(8'h10);
    chk("ctrl flag cleared", rdata, 8'h10);
    lk(8'h82);
    repeat (4) @(posedge clk);
    t_reset();
    $display("test immediate done");
  endtask

  // Whole run needs well under 6000 cycles
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    rst   = 1'b1;
    wr    = 1'b0;
    idone = 1'b0;
    smon  = 1'b0;
    gie   = 1'b0; // Global enable off: watchdog must not care
    wdata = 8'h00;
    error_cnt = 0;
    tests_run = 0;
    t_reset();
    t_lock();
    t_smon();
    t_count();
    t_immed();
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: logic/wdt_control.sv */
// Watchdog timer with locked control register.
// Assumes a core that writes one byte per write strobe.
// Overview of operation
// - Codes 0-7 select doubling periods, 15.6-2000ms
// - Code 8 resets at once; above 8 reserved
// - Interrupt mode raises interrupt, else reset
// - Watchdog interrupt ignores global enable
// - Any timeout sets status flag
// - Flag cleared by written zero or hardware reset
// - Writing enable one restarts counter
// - Missing refresh before period causes action
// - Enable cleared by zero, reset, supply monitor
// - Write accepted only right after unlock
// - 16-bit counter ticked at 32.768 kHz
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
module wdt_control
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  // Register access
  input  wire logic       CTRL_WR,
  input  wire logic [7:0] CTRL_WDATA,
  input  wire logic       INSTR_DONE,
  output logic      [7:0] CTRL_RDATA,
  // System events
  input  wire logic       SUPPLY_MONITOR_IRQ,
  input  wire logic       GLOBAL_IRQ_ENABLE,
  output logic            WDT_IRQ,
  output logic            WDT_SYS_RESET
);
  logic [3:0] sel_reg, sel_next;
  logic       irqm_reg, irqm_next;
  logic       flag_reg, flag_next;
  logic       en_reg, en_next;
  logic       unl_reg, unl_next;
  logic       arm_reg, arm_next;
  logic       irq_reg, irq_next;
  logic       srst_reg, srst_next;
  wdt_cnt_t   cnt_reg, cnt_next;
  wdt_state_e st_reg, st_next;
  logic       tick;
  logic       wr_ok;
  logic       restart;
  logic       expire;
  wdt_cnt_t   limit;

  // Period = 2^sel * 512 ticks
  assign limit = wdt_cnt_t'(`WDT_BASE_TICKS << sel_reg[2:0]);
  assign wr_ok = CTRL_WR && arm_reg;
  assign restart = wr_ok && CTRL_WDATA[`WDT_BIT_ENABLE];

  wdt_timebase u_tb (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .clear (restart),
    .tick  (tick)
  );

  // Expiry when counter reaches selected limit
  assign expire = en_reg && !restart && tick &&
                  (sel_reg <= `WDT_SEL_MAXCODE) &&
                  (cnt_reg == limit - wdt_cnt_t'(1));

  always_comb begin
    sel_next  = sel_reg;
    irqm_next = irqm_reg;
    flag_next = flag_reg;
    en_next   = en_reg;
    unl_next  = unl_reg;
    arm_next  = arm_reg;
    cnt_next  = cnt_reg;
    st_next   = st_reg;
    irq_next  = 1'b0;
    srst_next = 1'b0;
    // Unlock arms at its own instruction end, lives one instruction
    if (CTRL_WR && !arm_reg && CTRL_WDATA[`WDT_BIT_UNLOCK]) begin
      unl_next = 1'b1;
    end
    if (INSTR_DONE) begin
      arm_next = unl_next;
      unl_next = 1'b0;
    end
    if (wr_ok) begin
      sel_next  = CTRL_WDATA[`WDT_SEL_MSB:`WDT_SEL_LSB];
      irqm_next = CTRL_WDATA[`WDT_BIT_IRQMODE];
      en_next   = CTRL_WDATA[`WDT_BIT_ENABLE];
      arm_next  = 1'b0;
      unl_next  = 1'b0;
      if (!CTRL_WDATA[`WDT_BIT_FLAG]) begin
        flag_next = 1'b0;
      end
    end
    if (restart) begin
      cnt_next = '0;
    end else if (en_reg && tick) begin
      cnt_next = cnt_reg + wdt_cnt_t'(1);
    end
    case (st_reg)
      WDT_IDLE: if (en_next) st_next = WDT_RUN;
      WDT_RUN: begin
        if (!en_next) begin
          st_next = WDT_IDLE;
        end else if (expire) begin
          st_next = WDT_FIRE;
        end
      end
      WDT_FIRE: st_next = en_next ? WDT_RUN : WDT_IDLE;
      default: st_next = WDT_IDLE;
    endcase
    if (expire) begin
      flag_next = 1'b1;
      cnt_next  = '0;
      if (irqm_reg) begin
        irq_next = 1'b1;
      end else begin
        srst_next = 1'b1;
        en_next   = 1'b0;
      end
    end
    // Code 8 resets at once, whatever the enable
    if (sel_reg == `WDT_SEL_IMMED && !srst_reg) begin
      srst_next = 1'b1;
      flag_next = 1'b1;
      en_next   = 1'b0;
    end
    if (SUPPLY_MONITOR_IRQ) begin
      en_next = 1'b0;
      if (st_next == WDT_RUN) st_next = WDT_IDLE;
    end
  end

  // Watchdog reset keeps flag, period and mode but clears enable; RESET clears all but the period code, which loads 1
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sel_reg  <= 4'(`WDT_CTRL_RESET >> `WDT_SEL_LSB);
      irqm_reg <= 1'b0;
      flag_reg <= 1'b0;
      en_reg   <= 1'b0;
      unl_reg  <= 1'b0;
      arm_reg  <= 1'b0;
      cnt_reg  <= '0;
      st_reg   <= WDT_IDLE;
      irq_reg  <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      sel_reg  <= sel_next;
      irqm_reg <= irqm_next;
      flag_reg <= flag_next;
      en_reg   <= en_next;
      unl_reg  <= unl_next;
      arm_reg  <= arm_next;
      cnt_reg  <= cnt_next;
      st_reg   <= st_next;
      irq_reg  <= irq_next;
      srst_reg <= srst_next;
    end
  end

  // Not gated by global enable; fixed high priority
  assign WDT_IRQ = irq_reg;
  assign WDT_SYS_RESET = srst_reg;
  // Bit 0 reads back an unlock still pending or armed
  assign CTRL_RDATA = {sel_reg, irqm_reg, flag_reg, en_reg,
                       unl_reg | arm_reg};

  property p_wr_locked;
    @(posedge CORE_CLK) disable iff (RESET)
      (CTRL_WR && !arm_reg && !CTRL_WDATA[`WDT_BIT_UNLOCK])
        |=> $stable(sel_reg) && $stable(irqm_reg);
  endproperty
  a_wr_locked: assert property (p_wr_locked)
    else $error("Locked write changed settings");

  property p_arm_drop;
    @(posedge CORE_CLK) disable iff (RESET)
      (INSTR_DONE && arm_reg && !CTRL_WR) |=> !arm_reg;
  endproperty
  a_arm_drop: assert property (p_arm_drop)
    else $error("Unlock outlived the next instruction");

  property p_refresh;
    @(posedge CORE_CLK) disable iff (RESET)
      restart |=> cnt_reg == '0 &&
        (en_reg || $past(SUPPLY_MONITOR_IRQ) ||
         $past(sel_reg) == `WDT_SEL_IMMED);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("Refresh did not clear counter");

  property p_flag_set;
    @(posedge CORE_CLK) disable iff (RESET)
      expire |=> flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Timeout did not set flag");

  property p_flag_hold;
    @(posedge CORE_CLK) disable iff (RESET)
      (flag_reg && !wr_ok) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Flag lost without write");

  property p_irq_mode;
    @(posedge CORE_CLK) disable iff (RESET)
      (expire && irqm_reg) |=> WDT_IRQ && !WDT_SYS_RESET && en_reg;
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("Interrupt mode misbehaved");

  property p_rst_mode;
    @(posedge CORE_CLK) disable iff (RESET)
      (expire && !irqm_reg) |=> WDT_SYS_RESET && !en_reg;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("Reset mode misbehaved");

  property p_psm;
    @(posedge CORE_CLK) disable iff (RESET)
      SUPPLY_MONITOR_IRQ |=> !en_reg;
  endproperty
  a_psm: assert property (p_psm)
    else $error("Supply monitor left enable set");

  property p_immed;
    @(posedge CORE_CLK) disable iff (RESET)
      (sel_reg == `WDT_SEL_IMMED) |-> ##[0:1] WDT_SYS_RESET;
  endproperty
  a_immed: assert property (p_immed)
    else $error("Code eight gave no reset");

  property p_periodic;
    @(posedge CORE_CLK) disable iff (RESET)
      (expire && irqm_reg) |=> cnt_reg == '0;
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("Counter not restarted");
endmodule
`default_nettype wire

/* File: logic/wdt_defines.svh */
// Constants of the watchdog control block.
// Assumes inclusion by bare name; definitions only.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_BIT_UNLOCK   0
`define WDT_BIT_ENABLE   1
`define WDT_BIT_FLAG     2
`define WDT_BIT_IRQMODE  3
`define WDT_SEL_LSB      4
`define WDT_SEL_MSB      7
`define WDT_CTRL_RESET   8'h10
`define WDT_SEL_MAXCODE  4'h7
`define WDT_SEL_IMMED    4'h8
`define WDT_CLK_HZ       50000000
`define WDT_TB_HZ        32768
`define WDT_TB_DIV       (`WDT_CLK_HZ / `WDT_TB_HZ)
`define WDT_BASE_TICKS   16'h0200
`define WDT_CNT_W        16
`define WDT_DIV_W        11
`endif

/* File: logic/wdt_pkg.sv */
// Types of the watchdog control block.
// Assumes no surroundings.
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_IDLE,
    WDT_RUN,
    WDT_FIRE
  } wdt_state_e;
  typedef logic [15:0] wdt_cnt_t;
endpackage

/* File: logic/wdt_timebase.sv */
// Divider making the 32.768 kHz watchdog tick from the core clock.
// Assumes CORE_CLK at 50 MHz; clear restarts the phase.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
module wdt_timebase
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic clear,
  // Tick out
  output logic      tick
);
  logic [`WDT_DIV_W-1:0] div_reg;
  logic [`WDT_DIV_W-1:0] div_next;
  // Rounds down; tick rate sits a hair above nominal
  localparam logic [`WDT_DIV_W-1:0] DIV_LAST =
    `WDT_DIV_W'(`WDT_TB_DIV - 1);

  always_comb begin
    div_next = div_reg + `WDT_DIV_W'(1);
    if (clear || div_reg == DIV_LAST) begin
      div_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick = (div_reg == DIV_LAST) && !clear;
endmodule
`default_nettype wire
